// >>> secl_loader.sv
// Serial EEPROM configuration loader and page programmer
`timescale 1ns/10ps
`default_nettype none
module secl_loader
	import secl_pkg::*;
#(
	parameter int WRITE_CYCLE_CYC = EE_WRITE_CYC
) (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_in,
	input  wire logic        clk_link_in,
	input  wire logic [11:0] reg_addr_in,
	input  wire logic        reg_write_in,
	input  wire logic        reg_read_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic [31:0]      reg_rdata_out,
	output logic             reg_ack_out,
	input  wire logic        loader_enable_pin_in,
	input  wire logic        card_mode_pin_in,
	input  wire logic        card_info_select_pin_in,
	input  wire logic        eeprom_sda_in,
	output logic             eeprom_scl_out,
	output logic             eeprom_sda_out,
	output logic             eeprom_sda_oe_n_out,
	output logic [31:0]      cfg_subsystem_out,
	output logic [7:0]       cfg_max_latency_out,
	output logic [7:0]       cfg_min_grant_out,
	output logic [3:0]       bus_option_max_rec_out,
	output logic [31:0]      unique_id_high_out,
	output logic [31:0]      unique_id_low_out,
	output logic [127:0]     cfg_user_words_out,
	output logic             phy_programming_allowed_out,
	output logic             phy_enhancement_on_out,
	input  wire logic [4:0]  cis_index_in,
	output logic [31:0]      cis_word_out,
	output logic             load_done_out,
	output logic             busy_out
);
	typedef enum logic [2:0] {S_BOOT, S_LOAD, S_IDLE, S_WRITE, S_SETTLE} secl_state_t;
	secl_state_t state;
	logic [2:0]  pin_meta, pin_sync;
	logic        ack_toggle, ack_meta, ack_sync, ack_seen, ack_pulse;
	logic [1:0]  boot_cnt;
	logic        with_cis, ld_last;
	logic        req_toggle, req_write;
	logic [7:0]  req_addr;
	logic [63:0] req_data;
	logic [17:0] wcnt;
	logic [7:0]  rd_byte;
	logic [23:0] load_sh;
	logic [31:0] load_word;
	logic        store_now;
	logic [5:0]  store_ix;
	logic [2:0]  page_sel;
	logic        commit;
	logic [3:0]  cis_pair;
	logic [7:0]  next_page_addr;
	logic [63:0] next_page_data;
	logic [31:0] subsys, uid_hi, uid_lo, cis_even, cis_odd;
	logic [7:0]  max_lat, min_grant;
	logic [3:0]  max_rec;
	logic        phy_prog, phy_enh;
	logic [31:0] user_word [0:3];
	logic [31:0] cis_mem [0:31];

	function automatic logic is_user(input logic [11:0] a);
		return a[11:4] == OFS_USER[11:4];
	endfunction

	// Pin synchronisers
	always_ff @(posedge clk_sys_in) begin
		pin_meta <= {loader_enable_pin_in, card_mode_pin_in, card_info_select_pin_in};
		pin_sync <= pin_meta;
	end

	// Completion from the link side
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
			ack_seen <= 1'b0;
		end else begin
			ack_meta <= ack_toggle;
			ack_sync <= ack_meta;
			ack_seen <= ack_sync;
		end
	end
	assign ack_pulse = ack_sync != ack_seen;

	// Commit decode
	assign page_sel = reg_wdata_in[CTRL_PAGE_LSB +: 3];
	assign commit = reg_write_in && reg_addr_in == OFS_CTRL && reg_wdata_in[CTRL_COMMIT_BIT]
		&& page_sel <= PAGE_CIS && state == S_IDLE;

	// Page image, most significant byte first
	always_comb begin
		next_page_addr = EE_SUBSYS;
		next_page_data = 64'h0;
		case (page_sel)
			PAGE_SUBSYS: next_page_data = {subsys, max_lat, min_grant, EE_LAT_FIX, 4'h0, max_rec};
			PAGE_UID: begin
				next_page_addr = EE_UID;
				next_page_data = {uid_hi, uid_lo};
			end
			PAGE_USER_LO: begin
				next_page_addr = EE_USER_LO;
				next_page_data = {user_word[0], user_word[1]};
			end
			PAGE_USER_HI: begin
				next_page_addr = EE_USER_HI;
				next_page_data = {user_word[2], user_word[3]};
			end
			PAGE_PHY: begin
				next_page_addr = EE_PHY;
				next_page_data = {16'h0000, 6'h00, phy_prog, phy_enh, EE_PHY_FIX, 32'h0};
			end
			PAGE_CIS: begin
				next_page_addr = EE_CIS + {1'b0, cis_pair, 3'h0};
				next_page_data = {cis_even, cis_odd};
			end
			default: next_page_addr = EE_SUBSYS;
		endcase
	end

	// CIS pair pointer advances per CIS commit
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			cis_pair <= 4'h0;
		end else if (commit && page_sel == PAGE_CIS) begin
			cis_pair <= cis_pair + 4'h1;
		end
	end

	// Sequencer: boot load, page writes, write settle
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state <= S_BOOT;
			boot_cnt <= 2'h0;
			with_cis <= 1'b0;
			ld_last <= 1'b0;
			req_toggle <= 1'b0;
			req_write <= 1'b0;
			req_addr <= 8'h00;
			req_data <= 64'h0;
			wcnt <= 18'h0;
		end else begin
			ld_last <= 1'b0;
			unique case (state)
				S_BOOT: begin
					boot_cnt <= boot_cnt + 2'h1;
					if (boot_cnt == BOOT_WAIT) begin
						if (pin_sync[2]) begin
							with_cis <= pin_sync[1] | ~pin_sync[0];
							req_write <= 1'b0;
							req_addr <= EE_SUBSYS;
							req_toggle <= ~req_toggle;
							state <= S_LOAD;
						end else begin
							ld_last <= 1'b1;
							state <= S_IDLE;
						end
					end
				end
				S_LOAD: begin
					if (ack_pulse) begin
						if (req_addr == (with_cis ? EE_LAST_CIS : EE_LAST_BASE)) begin
							ld_last <= 1'b1;
							state <= S_IDLE;
						end else begin
							req_addr <= req_addr + 8'h01;
							req_toggle <= ~req_toggle;
						end
					end
				end
				S_IDLE: begin
					if (commit) begin
						req_write <= 1'b1;
						req_addr <= next_page_addr;
						req_data <= next_page_data;
						req_toggle <= ~req_toggle;
						state <= S_WRITE;
					end
				end
				S_WRITE: begin
					if (ack_pulse) begin
						wcnt <= 18'h0;
						state <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					wcnt <= wcnt + 18'h1;
					if (wcnt == 18'(WRITE_CYCLE_CYC - 1)) state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Load byte assembly
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			load_sh <= 24'h0;
		end else if (state == S_LOAD && ack_pulse) begin
			load_sh <= {load_sh[15:0], rd_byte};
		end
	end
	assign load_word = {load_sh, rd_byte};
	assign store_now = state == S_LOAD && ack_pulse && req_addr[1:0] == 2'h3;
	assign store_ix = req_addr[7:2];

	// Staging registers: software writes, then loaded words
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			subsys <= {SUBSYS_ID_RESET, SUBVEND_ID_RESET};
			max_lat <= LATENCY_RESET;
			min_grant <= LATENCY_RESET;
			max_rec <= MAXREC_RESET;
			uid_hi <= 32'h0;
			uid_lo <= 32'h0;
			phy_prog <= PHY_PROG_RESET;
			phy_enh <= PHY_ENH_RESET;
			cis_even <= 32'h0;
			cis_odd <= 32'h0;
			for (int i = 0; i < 4; i++) user_word[i] <= 32'h0;
		end else begin
			if (reg_write_in) begin
				if (is_user(reg_addr_in)) user_word[reg_addr_in[3:2]] <= reg_wdata_in;
				case (reg_addr_in)
					OFS_SUBSYS: subsys <= reg_wdata_in;
					OFS_LAT: begin
						max_lat <= reg_wdata_in[LAT_MAXLAT_LSB +: 8];
						min_grant <= reg_wdata_in[LAT_MINGNT_LSB +: 8];
						max_rec <= reg_wdata_in[LAT_MAXREC_LSB +: 4];
					end
					OFS_UIDH: uid_hi <= reg_wdata_in;
					OFS_UIDL: uid_lo <= reg_wdata_in;
					OFS_PHY: begin
						phy_prog <= reg_wdata_in[PHY_PROG_BIT];
						phy_enh <= reg_wdata_in[PHY_ENH_BIT];
					end
					OFS_CIS_EVEN: cis_even <= reg_wdata_in;
					OFS_CIS_ODD: cis_odd <= reg_wdata_in;
					default: ;
				endcase
			end
			if (store_now) begin
				if (store_ix[5:2] == 4'h1) user_word[store_ix[1:0]] <= load_word;
				case (store_ix)
					WIX_SUBSYS: subsys <= load_word;
					WIX_LAT: begin
						max_lat <= load_word[LAT_MAXLAT_LSB +: 8];
						min_grant <= load_word[LAT_MINGNT_LSB +: 8];
						max_rec <= load_word[LAT_MAXREC_LSB +: 4];
					end
					WIX_UIDH: uid_hi <= load_word;
					WIX_UIDL: uid_lo <= load_word;
					WIX_PHY: begin
						phy_prog <= load_word[PHY_PROG_BIT];
						phy_enh <= load_word[PHY_ENH_BIT];
					end
					default: ;
				endcase
			end
		end
	end

	// CIS area image
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			for (int i = 0; i < 32; i++) cis_mem[i] <= 32'h0;
		end else if (store_now && store_ix >= WIX_CIS) begin
			cis_mem[5'(store_ix - WIX_CIS)] <= load_word;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) cis_word_out <= 32'h0;
		else cis_word_out <= cis_mem[cis_index_in];
	end

	// Loaded values reach their destination registers
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			cfg_subsystem_out <= {SUBSYS_ID_RESET, SUBVEND_ID_RESET};
			cfg_max_latency_out <= LATENCY_RESET;
			cfg_min_grant_out <= LATENCY_RESET;
			bus_option_max_rec_out <= MAXREC_RESET;
			unique_id_high_out <= 32'h0;
			unique_id_low_out <= 32'h0;
			cfg_user_words_out <= 128'h0;
			phy_programming_allowed_out <= PHY_PROG_RESET;
			phy_enhancement_on_out <= PHY_ENH_RESET;
			load_done_out <= 1'b0;
		end else if (ld_last) begin
			cfg_subsystem_out <= subsys;
			cfg_max_latency_out <= max_lat;
			cfg_min_grant_out <= min_grant;
			bus_option_max_rec_out <= max_rec;
			unique_id_high_out <= uid_hi;
			unique_id_low_out <= uid_lo;
			cfg_user_words_out <= {user_word[0], user_word[1], user_word[2], user_word[3]};
			phy_programming_allowed_out <= phy_prog;
			phy_enhancement_on_out <= phy_enh;
			load_done_out <= 1'b1;
		end
	end

	// Register reads
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h0;
			reg_ack_out <= 1'b0;
			busy_out <= 1'b1;
		end else begin
			reg_ack_out <= reg_read_in | reg_write_in;
			busy_out <= state != S_IDLE;
			if (reg_read_in) begin
				reg_rdata_out <= 32'h0;
				if (is_user(reg_addr_in)) reg_rdata_out <= user_word[reg_addr_in[3:2]];
				case (reg_addr_in)
					OFS_SUBSYS: reg_rdata_out <= subsys;
					OFS_LAT: reg_rdata_out <= {max_lat, min_grant, 12'h000, max_rec};
					OFS_UIDH: reg_rdata_out <= uid_hi;
					OFS_UIDL: reg_rdata_out <= uid_lo;
					OFS_PHY: reg_rdata_out <= {22'h0, phy_prog, phy_enh, 8'h00};
					OFS_CIS_EVEN: reg_rdata_out <= cis_even;
					OFS_CIS_ODD: reg_rdata_out <= cis_odd;
					default: ;
				endcase
			end
		end
	end

	// Two-wire master on the link clock
	secl_twi_link u_link (
		.clk_link_in    (clk_link_in),
		.reset_in       (reset_in),
		.req_toggle_in  (req_toggle),
		.req_write_in   (req_write),
		.req_addr_in    (req_addr),
		.req_data_in    (req_data),
		.ack_toggle_out (ack_toggle),
		.rd_byte_out    (rd_byte),
		.sda_in         (eeprom_sda_in),
		.scl_out        (eeprom_scl_out),
		.sda_out        (eeprom_sda_out),
		.sda_oe_n_out   (eeprom_sda_oe_n_out)
	);
endmodule
`default_nettype wire

// >>> secl_pkg.sv
// Constants shared by the serial EEPROM configuration loader
`default_nettype none
package secl_pkg;
	// Register offsets in the memory window
	localparam logic [11:0] OFS_SUBSYS   = 12'h930;
	localparam logic [11:0] OFS_LAT      = 12'h934;
	localparam logic [11:0] OFS_UIDH     = 12'h938;
	localparam logic [11:0] OFS_UIDL     = 12'h93C;
	localparam logic [11:0] OFS_CTRL     = 12'h940;
	localparam logic [11:0] OFS_USER     = 12'h950;
	localparam logic [11:0] OFS_PHY      = 12'h960;
	localparam logic [11:0] OFS_CIS_EVEN = 12'h980;
	localparam logic [11:0] OFS_CIS_ODD  = 12'h984;
	// Field positions
	localparam int CTRL_COMMIT_BIT = 0;
	localparam int CTRL_PAGE_LSB   = 4;
	localparam int LAT_MAXLAT_LSB  = 24;
	localparam int LAT_MINGNT_LSB  = 16;
	localparam int LAT_MAXREC_LSB  = 0;
	localparam int PHY_PROG_BIT    = 9;
	localparam int PHY_ENH_BIT     = 8;
	// Reset values; identity values are arbitrary
	localparam logic [15:0] SUBSYS_ID_RESET  = 16'h0001;
	localparam logic [15:0] SUBVEND_ID_RESET = 16'h0001;
	localparam logic [7:0]  LATENCY_RESET    = 8'h00;
	localparam logic [3:0]  MAXREC_RESET     = 4'h9;
	localparam logic        PHY_PROG_RESET   = 1'b1;
	localparam logic        PHY_ENH_RESET    = 1'b0;
	// Page codes
	localparam logic [2:0] PAGE_SUBSYS  = 3'h0;
	localparam logic [2:0] PAGE_UID     = 3'h1;
	localparam logic [2:0] PAGE_USER_LO = 3'h2;
	localparam logic [2:0] PAGE_USER_HI = 3'h3;
	localparam logic [2:0] PAGE_PHY     = 3'h4;
	localparam logic [2:0] PAGE_CIS     = 3'h5;
	// EEPROM byte layout
	localparam logic [7:0] EE_SUBSYS    = 8'h00;
	localparam logic [7:0] EE_UID       = 8'h08;
	localparam logic [7:0] EE_USER_LO   = 8'h10;
	localparam logic [7:0] EE_USER_HI   = 8'h18;
	localparam logic [7:0] EE_PHY       = 8'h20;
	localparam logic [7:0] EE_CIS       = 8'h28;
	localparam logic [7:0] EE_LAST_BASE = 8'h27;
	localparam logic [7:0] EE_LAST_CIS  = 8'hA7;
	localparam logic [7:0] EE_LAT_FIX   = 8'h08;
	localparam logic [7:0] EE_PHY_FIX   = 8'h07;
	// Word indexes of the load stream
	localparam logic [5:0] WIX_SUBSYS = 6'h00;
	localparam logic [5:0] WIX_LAT    = 6'h01;
	localparam logic [5:0] WIX_UIDH   = 6'h02;
	localparam logic [5:0] WIX_UIDL   = 6'h03;
	localparam logic [5:0] WIX_PHY    = 6'h08;
	localparam logic [5:0] WIX_CIS    = 6'h0A;
	// Two-wire device addresses
	localparam logic [7:0] TWI_DEV_WR = 8'hA0;
	localparam logic [7:0] TWI_DEV_RD = 8'hA1;
	// Timing
	localparam int SYS_CLK_NS      = 50;
	localparam int LINK_CLK_NS     = 64;
	localparam int SCL_QUARTER_NS  = 2500;
	localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
	localparam int EE_WRITE_NS     = 10000000;
	localparam int EE_WRITE_CYC    = (EE_WRITE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam logic [1:0] BOOT_WAIT = 2'h3;
endpackage
`default_nettype wire

// >>> secl_twi_link.sv
// Two-wire EEPROM master on the link clock
`timescale 1ns/10ps
`default_nettype none
module secl_twi_link
	import secl_pkg::*;
(
	input  wire logic        clk_link_in,
	input  wire logic        reset_in,
	input  wire logic        req_toggle_in,
	input  wire logic        req_write_in,
	input  wire logic [7:0]  req_addr_in,
	input  wire logic [63:0] req_data_in,
	output logic             ack_toggle_out,
	output logic [7:0]       rd_byte_out,
	input  wire logic        sda_in,
	output logic             scl_out,
	output logic             sda_out,
	output logic             sda_oe_n_out
);
	typedef enum logic [1:0] {L_IDLE, L_START, L_BITS, L_STOP} secl_link_state_t;
	secl_link_state_t state;
	logic        rst_meta, rst_link, req_meta, req_sync, req_seen, sda_meta, sda_sync;
	logic [5:0]  qcnt;
	logic [1:0]  phase;
	logic [3:0]  bit_cnt, byte_idx;
	logic [7:0]  shreg;
	logic        wr_op;
	logic [7:0]  addr_q;
	logic [63:0] data_q;
	logic        tick, last_byte;
	assign tick      = qcnt == 6'(SCL_QUARTER_CYC - 1);
	assign last_byte = byte_idx == (wr_op ? 4'h9 : 4'h3);
	function automatic logic [7:0] tx_byte(input logic [3:0] i, input logic w, input logic [7:0] a,
		input logic [63:0] d);
		if (i == 4'h0) return TWI_DEV_WR;
		if (i == 4'h1) return a;
		if (w) return d[63 - 8 * (i - 4'h2) -: 8];
		return (i == 4'h2) ? TWI_DEV_RD : 8'hFF;
	endfunction
	// Crossings from the host clock and from the SDA pin
	always_ff @(posedge clk_link_in) begin
		rst_meta <= reset_in;
		rst_link <= rst_meta;
		req_meta <= req_toggle_in;
		req_sync <= req_meta;
		sda_meta <= sda_in;
		sda_sync <= sda_meta;
	end
	always_ff @(posedge clk_link_in) begin
		qcnt <= tick ? 6'h00 : qcnt + 6'h01;
	end
	always_ff @(posedge clk_link_in) begin
		if (rst_link) begin
			state <= L_IDLE;
			req_seen <= 1'b0;
			ack_toggle_out <= 1'b0;
			rd_byte_out <= 8'h00;
			scl_out <= 1'b1;
			sda_out <= 1'b0;
			sda_oe_n_out <= 1'b1;
			phase <= 2'h0;
			bit_cnt <= 4'h0;
			byte_idx <= 4'h0;
			shreg <= 8'h00;
			wr_op <= 1'b0;
			addr_q <= 8'h00;
			data_q <= 64'h0;
		end else if (state == L_IDLE) begin
			if (req_sync != req_seen) begin
				req_seen <= req_sync;
				wr_op <= req_write_in;
				addr_q <= req_addr_in;
				data_q <= req_data_in;
				byte_idx <= 4'h0;
				phase <= 2'h0;
				state <= L_START;
			end
		end else if (tick) begin
			phase <= phase + 2'h1;
			unique case (state)
				L_START: begin
					unique case (phase)
						2'h0: begin
							sda_oe_n_out <= 1'b1;
							scl_out <= 1'b0;
						end
						2'h1: scl_out <= 1'b1;
						2'h2: sda_oe_n_out <= 1'b0;
						2'h3: begin
							scl_out <= 1'b0;
							bit_cnt <= 4'h0;
							shreg <= tx_byte(byte_idx, wr_op, addr_q, data_q);
							state <= L_BITS;
						end
					endcase
				end
				L_BITS: begin
					unique case (phase)
						2'h0: sda_oe_n_out <= (bit_cnt == 4'h8) | shreg[7];
						2'h1: scl_out <= 1'b1;
						2'h2: if (bit_cnt != 4'h8) shreg <= {shreg[6:0], sda_sync};
						2'h3: begin
							scl_out <= 1'b0;
							if (bit_cnt != 4'h8) begin
								bit_cnt <= bit_cnt + 4'h1;
							end else if (last_byte) begin
								if (!wr_op) rd_byte_out <= shreg;
								state <= L_STOP;
							end else if (!wr_op && byte_idx == 4'h1) begin
								byte_idx <= byte_idx + 4'h1;
								state <= L_START;
							end else begin
								byte_idx <= byte_idx + 4'h1;
								bit_cnt <= 4'h0;
								shreg <= tx_byte(byte_idx + 4'h1, wr_op, addr_q, data_q);
							end
						end
					endcase
				end
				L_STOP: begin
					unique case (phase)
						2'h0: sda_oe_n_out <= 1'b0;
						2'h1: scl_out <= 1'b1;
						2'h2: sda_oe_n_out <= 1'b1;
						2'h3: begin
							ack_toggle_out <= ~ack_toggle_out;
							state <= L_IDLE;
						end
					endcase
				end
				default: state <= L_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> secl_loader_properties.sv
// Port assertions for the serial EEPROM configuration loader
`timescale 1ns/10ps
`default_nettype none
module secl_loader_properties
	import secl_pkg::*;
(
	input wire logic        clk_sys_in,
	input wire logic        reset_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic        reg_write_in,
	input wire logic        reg_read_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic        reg_ack_out,
	input wire logic        loader_enable_pin_in,
	input wire logic        eeprom_scl_out,
	input wire logic        eeprom_sda_oe_n_out,
	input wire logic [31:0] cfg_subsystem_out,
	input wire logic [3:0]  bus_option_max_rec_out,
	input wire logic [31:0] unique_id_low_out,
	input wire logic        phy_programming_allowed_out,
	input wire logic        load_done_out,
	input wire logic        busy_out
);
	logic ctrl_wr;
	logic rd_lat;
	logic rd_phy;
	assign ctrl_wr = reg_write_in && reg_addr_in == OFS_CTRL;
	assign rd_lat  = reg_read_in && reg_addr_in == OFS_LAT;
	assign rd_phy  = reg_read_in && reg_addr_in == OFS_PHY;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	a_ack_follows: assert property (
		(reg_write_in || reg_read_in) |=> reg_ack_out) else $error("ack missing");
	a_rdata_holds: assert property (
		!reg_read_in |=> $stable(reg_rdata_out)) else $error("read data moved");
	a_ctrl_zero: assert property (
		reg_read_in && reg_addr_in == OFS_CTRL |=> reg_rdata_out == 32'h0) else $error("control not zero");
	a_lat_resv: assert property (
		rd_lat |=> reg_rdata_out[15:4] == 12'h000) else $error("latency reserved bits");
	a_phy_resv: assert property (
		rd_phy |=> reg_rdata_out[31:10] == 22'h0 && reg_rdata_out[7:0] == 8'h00) else $error("phy reserved bits");
	a_off_defaults: assert property (
		$rose(load_done_out) && !loader_enable_pin_in |-> cfg_subsystem_out == {SUBSYS_ID_RESET, SUBVEND_ID_RESET}
		&& bus_option_max_rec_out == MAXREC_RESET && phy_programming_allowed_out == PHY_PROG_RESET)
		else $error("defaults wrong");
	a_loaded_stable: assert property (
		$past(load_done_out, 2) && load_done_out |-> $stable(cfg_subsystem_out) && $stable(unique_id_low_out))
		else $error("loaded value moved");
	a_commit_starts: assert property (
		ctrl_wr && reg_wdata_in[0] && reg_wdata_in[6:4] < 3'h6 && !busy_out && load_done_out |-> ##[1:2] busy_out)
		else $error("commit not started");
	a_zero_commit: assert property (
		(ctrl_wr && !reg_wdata_in[0] && !busy_out && !$past(ctrl_wr)) ##1 !reg_write_in |=> !busy_out)
		else $error("zero commit acted");
	a_bus_quiet: assert property (
		!busy_out && load_done_out |-> eeprom_scl_out && eeprom_sda_oe_n_out) else $error("bus not idle");
	cover property ($rose(load_done_out) && loader_enable_pin_in);
	cover property (ctrl_wr && reg_wdata_in[0] && !busy_out);
	cover property ($fell(busy_out));
endmodule
bind secl_loader secl_loader_properties u_props (
	.clk_sys_in, .reset_in, .reg_addr_in, .reg_write_in, .reg_read_in, .reg_wdata_in, .reg_rdata_out,
	.reg_ack_out, .loader_enable_pin_in, .eeprom_scl_out, .eeprom_sda_oe_n_out, .cfg_subsystem_out,
	.bus_option_max_rec_out, .unique_id_low_out, .phy_programming_allowed_out, .load_done_out, .busy_out
);
`default_nettype wire

// >>> secl_eeprom_model.sv
// Behavioural two-wire serial EEPROM
`timescale 1ns/10ps
`default_nettype none
module secl_eeprom_model (
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_low_out
);
	logic [7:0] mem [256];
	logic [7:0] sh, dat, addr;
	logic       idle, rd, rd_next;
	int         cnt, ph, rd_count;
	initial begin
		sda_low_out = 0;
		idle = 1;
		rd_count = 0;
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
	end
	always @(negedge sda_in) if (scl_in) begin
		idle = 0;
		cnt = 0;
		ph = 0;
		rd = 0;
		rd_next = 0;
		sda_low_out = 0;
	end
	always @(posedge sda_in) if (scl_in) begin
		idle = 1;
		sda_low_out = 0;
	end
	always @(posedge scl_in) if (!idle) begin
		if (cnt < 8)
			sh = {sh[6:0], sda_in};
		else if (rd && sda_in)
			idle = 1;
		cnt = cnt + 1;
	end
	always @(negedge scl_in) if (!idle) begin
		if (cnt == 9) begin
			cnt = 0;
			rd = rd_next;
			if (rd) begin
				dat = mem[addr];
				addr = addr + 8'h01;
				rd_count++;
			end
		end
		if (cnt == 8 && !rd) begin
			sda_low_out = 1;
			if (ph == 0)
				rd_next = sh[0];
			else if (ph == 1)
				addr = sh;
			else begin
				mem[addr] = sh;
				addr = addr + 8'h01;
			end
			ph = ph + 1;
		end else
			sda_low_out = rd && cnt < 8 && !dat[7 - cnt];
	end
endmodule
`default_nettype wire

// >>> secl_loader_bench.sv
// Self-checking bench for the serial EEPROM configuration loader
`timescale 1ns/10ps
`default_nettype none
module secl_loader_bench import secl_pkg::*;;
	logic         clk, lclk, rst, wr_s, rd_s, ack, en, mode, cis, scl, sda_o, oe_n, ee_low, prog, enh, done, busy;
	logic [11:0]  addr;
	logic [31:0]  wdata, rdata, subsys, uid_h, uid_l, cis_w;
	logic [7:0]   maxlat, mingnt;
	logic [3:0]   maxrec;
	logic [127:0] user;
	wire          sda = (oe_n ? 1'b1 : sda_o) && !ee_low;
	int           bad_count, total_checks;
	logic [31:0]  stage [12] = '{32'hA1B2C3D4, 32'h12340806, 32'h11223344, 32'h55667788, 32'h90000001,
		32'h90000002, 32'h90000003, 32'h90000004, 32'h00000107, 32'h0, 32'hCAFE0001, 32'hCAFE0002};
	logic [11:0]  where [12] = '{12'h930, 12'h934, 12'h938, 12'h93C, 12'h950, 12'h954, 12'h958, 12'h95C,
		12'h960, 12'h000, 12'h980, 12'h984};
	secl_loader #(.WRITE_CYCLE_CYC(20)) uut (.clk_sys_in(clk), .reset_in(rst), .clk_link_in(lclk),
		.reg_addr_in(addr), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.reg_ack_out(ack), .loader_enable_pin_in(en), .card_mode_pin_in(mode), .card_info_select_pin_in(cis),
		.eeprom_sda_in(sda), .eeprom_scl_out(scl), .eeprom_sda_out(sda_o), .eeprom_sda_oe_n_out(oe_n),
		.cfg_subsystem_out(subsys), .cfg_max_latency_out(maxlat), .cfg_min_grant_out(mingnt),
		.bus_option_max_rec_out(maxrec), .unique_id_high_out(uid_h), .unique_id_low_out(uid_l),
		.cfg_user_words_out(user), .phy_programming_allowed_out(prog), .phy_enhancement_on_out(enh),
		.cis_index_in(5'h00), .cis_word_out(cis_w), .load_done_out(done), .busy_out(busy));
	secl_eeprom_model ee (.scl_in(scl), .sda_in(sda), .sda_low_out(ee_low));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial begin
		lclk = 0;
		#13;
		forever #32 lclk = ~lclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_s <= w;
		rd_s <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 0;
		rd_s <= 0;
		#1;
		check(32'(ack), 32'h1, "ack");
	endtask
	task automatic rd_check(input logic [11:0] a, input logic [31:0] e, input string m);
		access(1'b0, a, 32'h0);
		check(rdata, e, m);
	endtask
	task automatic do_reset(input logic e);
		@(posedge clk);
		en <= e;
		rst <= 1;
		repeat (4) @(posedge clk);
		rst <= 0;
	endtask
	task automatic wait_idle(input int lim);
		int n = 0;
		repeat (2) @(posedge clk);
		while (!(done === 1'b1 && busy === 1'b0) && n < lim) begin
			@(posedge clk);
			n++;
		end
		check(32'(n < lim), 32'h1, "wait bound");
	endtask
	task automatic t_boot_off();
		do_reset(1'b0);
		wait_idle(60);
		check(subsys, {SUBSYS_ID_RESET, SUBVEND_ID_RESET}, "subsystem default");
		check(32'(maxrec), 32'h9, "max rec default");
		check(32'({prog, enh}), 32'h2, "phy defaults");
		check(32'(ee.rd_count), 32'h0, "reads while off");
		$display("test boot off done");
	endtask
	task automatic t_regs();
		access(1'b1, OFS_LAT, 32'hFFFF080F);
		rd_check(OFS_LAT, 32'hFFFF000F, "latency stage");
		access(1'b1, OFS_PHY, 32'h00000307);
		rd_check(OFS_PHY, 32'h00000300, "phy stage");
		access(1'b1, OFS_UIDH, 32'h89ABCDEF);
		rd_check(OFS_UIDH, 32'h89ABCDEF, "uid stage");
		rd_check(OFS_CTRL, 32'h0, "control read");
		rd_check(12'h9F0, 32'h0, "unmapped");
		check(32'(maxlat), 32'h0, "latency before load");
		$display("test registers done");
	endtask
	task automatic t_program();
		for (int i = 0; i < 12; i++)
			if (i != 9) access(1'b1, where[i], stage[i]);
		access(1'b1, OFS_CTRL, 32'h00000050);
		repeat (4) @(posedge clk);
		check(32'(busy), 32'h0, "zero commit");
		for (int p = 0; p < 6; p++) begin
			access(1'b1, OFS_CTRL, {25'h0, 3'(p), 4'h1});
			if (p == 0) access(1'b1, OFS_CTRL, 32'h00000051);
			wait_idle(40000);
		end
		for (int a = 0; a < 48; a++)
			check(32'(ee.mem[a]), 32'(stage[a / 4][8 * (3 - a % 4) +: 8]), "eeprom byte");
		$display("test program done");
	endtask
	task automatic t_load();
		do_reset(1'b1);
		wait_idle(700000);
		check(subsys, stage[0], "subsystem");
		check({maxlat, mingnt, 12'h0, maxrec}, 32'h12340006, "latency");
		check(uid_h, stage[2], "uid high");
		check(uid_l, stage[3], "uid low");
		for (int i = 0; i < 4; i++)
			check(user[127 - 32 * i -: 32], stage[4 + i], "user word");
		check(32'({prog, enh}), 32'h1, "phy bits");
		check(32'(ee.rd_count), 32'h28, "bytes read");
		check(cis_w, 32'h0, "no card info load");
		rd_check(OFS_SUBSYS, stage[0], "subsystem stage");
		$display("test load done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (1200000) @(posedge clk);
		bad_count++;
		$display("wrong value at %0t: run hung", $time);
		finish_test();
	end
	initial begin
		rst = 1;
		wr_s = 0;
		rd_s = 0;
		addr = 12'h000;
		wdata = 32'h0;
		en = 0;
		mode = 0;
		cis = 1;
		t_boot_off();
		t_regs();
		t_program();
		t_load();
		finish_test();
	end
endmodule
`default_nettype wire
